/* core/cwt_pkg.sv */
/*
  Constants and types for the carrier wave timer.
  Assumes one core clock at twice the oscillator rate and a plain register port.
*/
package cwt_pkg;

  // ----------------------------------------
  // Register port offsets
  // ----------------------------------------
  localparam logic [2:0] CWT_ADDR_CTRL = 3'h0;
  localparam logic [2:0] CWT_ADDR_LOAD_BOTH = 3'h1;
  localparam logic [2:0] CWT_ADDR_RESTORE = 3'h2;
  localparam logic [2:0] CWT_ADDR_HIGH = 3'h3;
  localparam logic [2:0] CWT_ADDR_COUNT = 3'h4;
  localparam logic [2:0] CWT_ADDR_SKIP1 = 3'h5;
  localparam logic [2:0] CWT_ADDR_SKIP2 = 3'h6;
  localparam logic [2:0] CWT_ADDR_LOW = 3'h7;

  // ----------------------------------------
  // Control field positions
  // ----------------------------------------
  localparam int CWT_BIT_RUN = 0;
  localparam int CWT_BIT_SRC = 1;
  localparam int CWT_BIT_CGEN = 2;
  localparam int CWT_BIT_STRETCH = 3;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [3:0] CWT_CTRL_RST = 4'h0;
  localparam logic [7:0] CWT_BYTE_RST = 8'h00;
  localparam logic [1:0] CWT_PRE_RST = 2'h0;

  // ----------------------------------------
  // Count-source timing in core cycles
  // ----------------------------------------
  localparam logic [1:0] CWT_PRE_LAST_FULL = 2'h1;
  localparam logic [1:0] CWT_PRE_LAST_HALF = 2'h3;
  localparam logic CWT_HALF_FULL = 1'h0;
  localparam logic CWT_HALF_HALF = 1'h1;

  // ----------------------------------------
  // Carrier phase
  // ----------------------------------------
  typedef enum logic [2:0] {
    CWT_PH_LOW = 3'b001,
    CWT_PH_HIGH = 3'b010,
    CWT_PH_STRETCH = 3'b100
  } cwt_phase_t;

endpackage : cwt_pkg

/* core/cwt_timer.sv */
/*
  Carrier wave timer: 8-bit down counter with low and high reload values,
  plain auto-reload or carrier generation, and the two underflow flags.
  Assumes core_clk runs at twice the oscillator rate, so a full-rate count
  pulse is every 2 cycles and a half-rate pulse every 4; the first timer's
  underflow arrives as a one-cycle pulse on the same clock.
*/
// How it works
// - Load-both write puts one byte into counter and low reload together.
// - Restore write copies low reload into counter, reload unchanged.
// - High reload write touches only the high reload value.
// - Plain mode: pulse at zero sets flag, reloads low, keeps counting.
// - Plain mode: one underflow each n plus one count pulses.
// - Carrier mode: output low for low reload, high for high reload.
// - Carrier mode starts low; its underflow sets flag, reloads high.
// - Each carrier underflow sets flag; reloads alternate high and low.
// - No stretch: high phase lasts n plus one count periods.
// - Stretch: high phase lasts n plus one and a half periods.
// - Low phase lasts m plus one count periods.
// - Count read returns the counter; software stops it first.
// - Each underflow sets its flag; each flag has its skip test.
// - Skip test clears a flag only when it skips, set one.
// - Stop during high phase finishes the whole high interval first.
// - Reset clears the four control bits and both flags.
// - Control bits: run, source divide, carrier enable, high stretch.
// - Clearing run outside a carrier high phase freezes the counter at its present value.
module cwt_timer (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [2:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rd_data,
  input wire logic first_underflow_event,
  output logic carrier_output_pin,
  output logic first_underflow_flag,
  output logic second_underflow_flag
);

  // ----------------------------------------
  // Decoding
  // ----------------------------------------

  // Count pulse for the selected source
  function automatic logic cwt_is_tick(input logic src, input logic [1:0] pre);
    cwt_is_tick = src ? (pre == cwt_pkg::CWT_PRE_LAST_HALF) : pre[0];
  endfunction : cwt_is_tick

  logic [3:0] second_timer_control_reg;
  logic [7:0] count_reg;
  logic [7:0] low_interval_reload_reg;
  logic [7:0] high_interval_reload_reg;
  logic [1:0] pre_reg;
  logic half_reg;
  cwt_pkg::cwt_phase_t phase_reg;
  logic run_bit;
  logic src_bit;
  logic cgen_bit;
  logic stretch_bit;
  logic active;
  logic tick;
  logic underflow;
  logic half_done;
  logic wr_load_both;
  logic wr_restore;
  logic wr_high;
  logic wr_ctrl;
  logic rd_skip1;
  logic rd_skip2;

  // Control fields and strobes
  assign run_bit = second_timer_control_reg[cwt_pkg::CWT_BIT_RUN];
  assign src_bit = second_timer_control_reg[cwt_pkg::CWT_BIT_SRC];
  assign cgen_bit = second_timer_control_reg[cwt_pkg::CWT_BIT_CGEN];
  assign stretch_bit = second_timer_control_reg[cwt_pkg::CWT_BIT_STRETCH];
  assign wr_ctrl = wr_stb && (addr == cwt_pkg::CWT_ADDR_CTRL);
  assign wr_load_both = wr_stb && (addr == cwt_pkg::CWT_ADDR_LOAD_BOTH);
  assign wr_restore = wr_stb && (addr == cwt_pkg::CWT_ADDR_RESTORE);
  assign wr_high = wr_stb && (addr == cwt_pkg::CWT_ADDR_HIGH);
  assign rd_skip1 = rd_stb && (addr == cwt_pkg::CWT_ADDR_SKIP1);
  assign rd_skip2 = rd_stb && (addr == cwt_pkg::CWT_ADDR_SKIP2);

  // Keep counting through a high phase after run is cleared
  assign active = run_bit || (cgen_bit && (phase_reg != cwt_pkg::CWT_PH_LOW));
  assign tick = active && (phase_reg != cwt_pkg::CWT_PH_STRETCH) && cwt_is_tick(src_bit, pre_reg);
  assign underflow = tick && (count_reg == cwt_pkg::CWT_BYTE_RST);
  assign half_done = cgen_bit && (phase_reg == cwt_pkg::CWT_PH_STRETCH)
      && (half_reg == cwt_pkg::CWT_HALF_FULL);

  // ----------------------------------------
  // Control and reload registers
  // ----------------------------------------

  // Control register write
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      second_timer_control_reg <= cwt_pkg::CWT_CTRL_RST;
    end else if (wr_ctrl) begin
      second_timer_control_reg <= wr_data[3:0];
    end
  end

  // Reload registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      low_interval_reload_reg <= cwt_pkg::CWT_BYTE_RST;
      high_interval_reload_reg <= cwt_pkg::CWT_BYTE_RST;
    end else begin
      if (wr_load_both) begin
        low_interval_reload_reg <= wr_data;
      end
      if (wr_high) begin
        high_interval_reload_reg <= wr_data;
      end
    end
  end

  // ----------------------------------------
  // Count-source prescaler and counter
  // ----------------------------------------

  // Prescaler, realigned when the low phase begins after a stretch
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pre_reg <= cwt_pkg::CWT_PRE_RST;
    end else if (!active || half_done) begin
      pre_reg <= cwt_pkg::CWT_PRE_RST;
    end else begin
      pre_reg <= pre_reg + 2'h1;
    end
  end

  // Counter: software loads win over counting
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      count_reg <= cwt_pkg::CWT_BYTE_RST;
    end else if (wr_load_both) begin
      count_reg <= wr_data;
    end else if (wr_restore) begin
      count_reg <= low_interval_reload_reg;
    end else if (half_done) begin
      count_reg <= low_interval_reload_reg;
    end else if (underflow) begin
      if (cgen_bit && (phase_reg == cwt_pkg::CWT_PH_LOW)) begin
        count_reg <= high_interval_reload_reg;
      end else begin
        count_reg <= low_interval_reload_reg;
      end
    end else if (tick) begin
      count_reg <= count_reg - 8'h01;
    end
  end

  // ----------------------------------------
  // Carrier phase and output
  // ----------------------------------------

  // Phase: low, high, then optional half-period stretch
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      phase_reg <= cwt_pkg::CWT_PH_LOW;
      half_reg <= cwt_pkg::CWT_HALF_FULL;
      carrier_output_pin <= 1'b0;
    end else if (!cgen_bit) begin
      phase_reg <= cwt_pkg::CWT_PH_LOW;
      carrier_output_pin <= 1'b0;
    end else begin
      case (phase_reg)
        cwt_pkg::CWT_PH_LOW: begin
          if (underflow) begin
            phase_reg <= cwt_pkg::CWT_PH_HIGH;
            carrier_output_pin <= 1'b1;
          end
        end
        cwt_pkg::CWT_PH_HIGH: begin
          if (underflow && stretch_bit) begin
            phase_reg <= cwt_pkg::CWT_PH_STRETCH;
            half_reg <= src_bit ? cwt_pkg::CWT_HALF_HALF : cwt_pkg::CWT_HALF_FULL;
          end else if (underflow) begin
            phase_reg <= cwt_pkg::CWT_PH_LOW;
            carrier_output_pin <= 1'b0;
          end
        end
        cwt_pkg::CWT_PH_STRETCH: begin
          if (half_done) begin
            phase_reg <= cwt_pkg::CWT_PH_LOW;
            carrier_output_pin <= 1'b0;
          end else begin
            half_reg <= cwt_pkg::CWT_HALF_FULL;
          end
        end
        default: begin
          phase_reg <= cwt_pkg::CWT_PH_LOW;
          carrier_output_pin <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Underflow flags and skip tests
  // ----------------------------------------

  // Set wins over the skip clear
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      first_underflow_flag <= 1'b0;
      second_underflow_flag <= 1'b0;
    end else begin
      if (first_underflow_event) begin
        first_underflow_flag <= 1'b1;
      end else if (rd_skip1 && first_underflow_flag) begin
        first_underflow_flag <= 1'b0;
      end
      if (underflow) begin
        second_underflow_flag <= 1'b1;
      end else if (rd_skip2 && second_underflow_flag) begin
        second_underflow_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Read data, valid only the cycle after a read
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rd_data <= cwt_pkg::CWT_BYTE_RST;
    end else if (rd_stb) begin
      case (addr)
        cwt_pkg::CWT_ADDR_CTRL: rd_data <= {4'h0, second_timer_control_reg};
        cwt_pkg::CWT_ADDR_HIGH: rd_data <= high_interval_reload_reg;
        cwt_pkg::CWT_ADDR_COUNT: rd_data <= count_reg;
        cwt_pkg::CWT_ADDR_SKIP1: rd_data <= {7'h00, first_underflow_flag};
        cwt_pkg::CWT_ADDR_SKIP2: rd_data <= {7'h00, second_underflow_flag};
        cwt_pkg::CWT_ADDR_LOW: rd_data <= low_interval_reload_reg;
        default: rd_data <= cwt_pkg::CWT_BYTE_RST;
      endcase
    end else begin
      rd_data <= cwt_pkg::CWT_BYTE_RST;
    end
  end

  // ----------------------------------------
  // Assertions and cover points
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  chk_load_both_pair: assert property (wr_load_both |=>
      (count_reg == $past(wr_data)) && (low_interval_reload_reg == $past(wr_data)))
    else $error("load-both did not fill counter and low reload");

  chk_restore_copy: assert property (wr_restore |=>
      (count_reg == $past(low_interval_reload_reg)) && $stable(low_interval_reload_reg))
    else $error("restore did not copy low reload");

  chk_high_only_write: assert property (wr_high && !tick && !half_done |=>
      (high_interval_reload_reg == $past(wr_data)) && $stable(count_reg)
      && $stable(low_interval_reload_reg))
    else $error("high reload write disturbed other state");

  chk_plain_reload: assert property (underflow && !cgen_bit && !wr_stb |=>
      (count_reg == $past(low_interval_reload_reg)) && second_underflow_flag)
    else $error("plain underflow did not reload and flag");

  chk_freeze_stop: assert property (!active && !wr_stb |=> $stable(count_reg))
    else $error("stopped counter moved");

  chk_count_step: assert property (tick && (count_reg != 8'h00) && !wr_stb |=>
      count_reg == $past(count_reg) - 8'h01)
    else $error("counter did not decrement by one");

  chk_low_to_high: assert property (underflow && cgen_bit && !wr_stb && !wr_ctrl
      && (phase_reg == cwt_pkg::CWT_PH_LOW) |=>
      carrier_output_pin && (count_reg == $past(high_interval_reload_reg)))
    else $error("low phase did not hand over to high reload");

  chk_skip_clear: assert property (rd_skip2 && second_underflow_flag && !underflow |=>
      !second_underflow_flag && (rd_data == 8'h01))
    else $error("skip test did not clear the flag");

  chk_stop_in_high: assert property (cgen_bit && (phase_reg != cwt_pkg::CWT_PH_LOW)
      && !run_bit && !wr_ctrl |=> active || !carrier_output_pin)
    else $error("timer halted inside the high phase");

  chk_stretch_half: assert property (half_done && cgen_bit && !wr_ctrl |=>
      !carrier_output_pin && (phase_reg == cwt_pkg::CWT_PH_LOW))
    else $error("stretch did not end in the low phase");

  chk_count_read: assert property (rd_stb && (addr == cwt_pkg::CWT_ADDR_COUNT) |=>
      rd_data == $past(count_reg))
    else $error("count read returned the wrong value");

  // Register writes, flag behaviour and phase hand-overs
  chk_ctrl_write: assert property (wr_ctrl |=>
      second_timer_control_reg == $past(wr_data[3:0]))
    else $error("control write did not land");

  chk_low_reload_hold: assert property (!wr_load_both |=>
      $stable(low_interval_reload_reg))
    else $error("low reload changed without a load-both write");

  chk_high_reload_hold: assert property (!wr_high |=>
      $stable(high_interval_reload_reg))
    else $error("high reload changed without its write");

  chk_flag_on_underflow: assert property (underflow |=> second_underflow_flag)
    else $error("underflow did not set the second flag");

  chk_first_flag_set: assert property (first_underflow_event |=> first_underflow_flag)
    else $error("first timer event did not set its flag");

  chk_flag_holds: assert property (!rd_skip2 && second_underflow_flag |=>
      second_underflow_flag)
    else $error("second flag cleared without a skip test");

  chk_first_skip_clear: assert property (rd_skip1 && first_underflow_flag
      && !first_underflow_event |=> !first_underflow_flag && (rd_data == 8'h01))
    else $error("first skip test did not clear its flag");

  chk_high_to_low: assert property (underflow && cgen_bit && !stretch_bit && !wr_stb
      && (phase_reg == cwt_pkg::CWT_PH_HIGH) |=> !carrier_output_pin
      && (count_reg == $past(low_interval_reload_reg)))
    else $error("high phase did not hand back to low reload");

  chk_high_to_stretch: assert property (underflow && cgen_bit && stretch_bit && !wr_ctrl
      && (phase_reg == cwt_pkg::CWT_PH_HIGH) |=> carrier_output_pin
      && (phase_reg == cwt_pkg::CWT_PH_STRETCH))
    else $error("stretch did not keep the output high");

  chk_plain_pin_low: assert property (!cgen_bit |=> !carrier_output_pin)
    else $error("carrier output high with carrier generation off");

  chk_halt_stays_low: assert property (!run_bit && !wr_ctrl
      && (phase_reg == cwt_pkg::CWT_PH_LOW) |=> (phase_reg == cwt_pkg::CWT_PH_LOW)
      && !carrier_output_pin)
    else $error("halted timer left the low phase");

  cov_plain_underflow: cover property (underflow && !cgen_bit);
  cov_first_skip: cover property (rd_skip1 && first_underflow_flag);
  cov_stretch_seen: cover property (phase_reg == cwt_pkg::CWT_PH_STRETCH);
  cov_skip_clear: cover property (rd_skip2 && second_underflow_flag);
  cov_stop_in_high: cover property (!run_bit && carrier_output_pin && active);

endmodule : cwt_timer

/* verification/cwt_carrier_rx.sv */
/*
  Receiver model on the carrier output pin: measures high and low widths.
  Assumes the same core clock and reset as the timer.
*/
module cwt_carrier_rx (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic carrier_output_pin,
  output logic [15:0] hi_len,
  output logic [15:0] lo_len,
  output logic [15:0] edge_cnt
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] run_len;
  logic last_lvl;

  // --------------------
  // Width of each level in core cycles
  // --------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      run_len <= 16'h0000;
      last_lvl <= 1'b0;
      hi_len <= 16'h0000;
      lo_len <= 16'h0000;
      edge_cnt <= 16'h0000;
    end else begin
      last_lvl <= carrier_output_pin;
      if (carrier_output_pin != last_lvl) begin
        run_len <= 16'h0001;
        edge_cnt <= edge_cnt + 16'h0001;
        if (last_lvl) begin
          hi_len <= run_len;
        end else begin
          lo_len <= run_len;
        end
      end else begin
        run_len <= run_len + 16'h0001;
      end
    end
  end
endmodule : cwt_carrier_rx

/* verification/testbench.sv */
/*
  Self-checking bench for the carrier wave timer.
  Assumes the timer and the carrier receiver model are compiled first.
*/
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wr_data = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic first_underflow_event = 1'b0;
  logic [7:0] rd_data;
  logic carrier_output_pin;
  logic first_underflow_flag;
  logic second_underflow_flag;
  logic [15:0] hi_len;
  logic [15:0] lo_len;
  logic [15:0] edge_cnt;
  logic [7:0] d;
  logic [7:0] d2;
  int error_cnt = 0;
  int n_checks = 0;

  always #12.5 core_clk = ~core_clk;

  cwt_timer uut (.core_clk(core_clk), .resetn(resetn), .addr(addr), .wr_data(wr_data),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
    .first_underflow_event(first_underflow_event), .carrier_output_pin(carrier_output_pin),
    .first_underflow_flag(first_underflow_flag), .second_underflow_flag(second_underflow_flag));
  cwt_carrier_rx rx (.core_clk(core_clk), .resetn(resetn),
    .carrier_output_pin(carrier_output_pin), .hi_len(hi_len), .lo_len(lo_len),
    .edge_cnt(edge_cnt));

  // --------------------
  // Bus cycles and comparison
  // --------------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge core_clk);
    addr <= a;
    wr_data <= v;
    wr_stb <= 1'b1;
    @(posedge core_clk);
    wr_stb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge core_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    #1;
    v = rd_data;
  endtask : rd

  // --------------------
  // Scenarios
  // --------------------
  task automatic t_reset;
    for (int i = 0; i < 8; i++) begin
      rd(3'(i), d);
      chk("reset read", d, 0);
    end
  endtask : t_reset
  task automatic t_loads;
    wr(cwt_pkg::CWT_ADDR_LOAD_BOTH, 8'h5a);
    wr(cwt_pkg::CWT_ADDR_HIGH, 8'h33);
    rd(cwt_pkg::CWT_ADDR_HIGH, d);
    chk("high reload", d, 8'h33);
    rd(cwt_pkg::CWT_ADDR_COUNT, d);
    chk("count after loads", d, 8'h5a);
    rd(cwt_pkg::CWT_ADDR_LOW, d);
    chk("low after loads", d, 8'h5a);
    wr(cwt_pkg::CWT_ADDR_CTRL, 8'h0e);
    rd(cwt_pkg::CWT_ADDR_CTRL, d);
    chk("control bits", d, 8'h0e);
    wr(cwt_pkg::CWT_ADDR_CTRL, 8'h01);
    repeat (40) @(posedge core_clk);
    wr(cwt_pkg::CWT_ADDR_CTRL, 8'h00);
    rd(cwt_pkg::CWT_ADDR_COUNT, d);
    repeat (10) @(posedge core_clk);
    rd(cwt_pkg::CWT_ADDR_COUNT, d2);
    chk("count frozen", d2, d);
    chk("count ran", 16'(d > 8'h40 && d < 8'h5a), 1);
    wr(cwt_pkg::CWT_ADDR_RESTORE, 8'h00);
    rd(cwt_pkg::CWT_ADDR_COUNT, d);
    chk("restored count", d, 8'h5a);
    rd(cwt_pkg::CWT_ADDR_LOW, d);
    chk("low kept", d, 8'h5a);
  endtask : t_loads
  task automatic t_plain(input logic [7:0] n, input logic src);
    int last = 0;
    int per = 0;
    int hits = 0;
    wr(cwt_pkg::CWT_ADDR_LOAD_BOTH, n);
    wr(cwt_pkg::CWT_ADDR_CTRL, {6'h00, src, 1'b1});
    @(posedge core_clk);
    addr <= cwt_pkg::CWT_ADDR_SKIP2;
    rd_stb <= 1'b1;
    for (int i = 0; i < 3000 && hits < 3; i++) begin
      @(posedge core_clk);
      #1;
      if (rd_data[0] === 1'b1) begin
        hits++;
        per = i - last;
        last = i;
      end
    end
    @(posedge core_clk);
    rd_stb <= 1'b0;
    chk("plain period", 16'(per), 16'((n + 1) * (src ? 4 : 2)));
    wr(cwt_pkg::CWT_ADDR_CTRL, 8'h00);
  endtask : t_plain
  task automatic t_carrier(input logic [7:0] m, n, input logic src, str);
    int p = src ? 4 : 2;
    logic [15:0] e0 = edge_cnt;
    rd(cwt_pkg::CWT_ADDR_SKIP2, d);
    chk("second flag cleared", second_underflow_flag, 0);
    wr(cwt_pkg::CWT_ADDR_LOAD_BOTH, m);
    wr(cwt_pkg::CWT_ADDR_HIGH, n);
    wr(cwt_pkg::CWT_ADDR_CTRL, {4'h0, str, 1'b1, src, 1'b1});
    for (int i = 0; i < 4000 && edge_cnt < e0 + 16'h0005; i++) @(posedge core_clk);
    #1;
    chk("low width", lo_len, 16'((m + 1) * p));
    chk("high width", hi_len, 16'((n + 1) * p + (str ? p / 2 : 0)));
    chk("second flag", second_underflow_flag, 1);
    for (int i = 0; i < 4000 && carrier_output_pin !== 1'b1; i++) @(posedge core_clk);
    wr(cwt_pkg::CWT_ADDR_CTRL, {4'h0, str, 1'b1, src, 1'b0});
    e0 = edge_cnt;
    repeat (600) @(posedge core_clk);
    chk("high after stop", hi_len, 16'((n + 1) * p + (str ? p / 2 : 0)));
    chk("edges after stop", edge_cnt, e0 + 16'h0001);
    rd(cwt_pkg::CWT_ADDR_COUNT, d);
    chk("count after stop", d, m);
    wr(cwt_pkg::CWT_ADDR_CTRL, 8'h00);
  endtask : t_carrier
  task automatic t_first;
    @(posedge core_clk);
    first_underflow_event <= 1'b1;
    @(posedge core_clk);
    first_underflow_event <= 1'b0;
    @(posedge core_clk);
    #1;
    chk("first flag pin", first_underflow_flag, 1);
    rd(cwt_pkg::CWT_ADDR_SKIP1, d);
    chk("first skip", d, 8'h01);
    rd(cwt_pkg::CWT_ADDR_SKIP1, d);
    chk("first after skip", d, 8'h00);
    chk("first flag clear", first_underflow_flag, 0);
  endtask : t_first

  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // Main sequence; software loads before run each time
  initial begin
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    t_reset;
    t_loads;
    t_plain(8'h00, 1'b0);
    t_plain(8'h03, 1'b1);
    t_plain(8'hff, 1'b0);
    t_carrier(8'h03, 8'h02, 1'b1, 1'b0);
    t_carrier(8'h00, 8'h03, 1'b0, 1'b1);
    t_carrier(8'h02, 8'hff, 1'b0, 1'b0);
    t_first;
    tally_and_finish;
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    tally_and_finish;
  end
endmodule : testbench
